// [rtc_tcc_pkg.sv]
// constants, field layouts and carrier types of the temperature compensation control block
// assumes a single 200 MHz clock domain and a byte-wide register port
package rtc_tcc_pkg;

  // register map
  localparam logic [7:0] ADDR_GAIN_CTL = 8'h0D;
  localparam logic [7:0] ADDR_FIN_AT   = 8'h0E;
  localparam logic [7:0] ADDR_FIN_DT   = 8'h0F;

  // reset values
  localparam logic [7:0] GAIN_CTL_RST  = 8'h00;
  localparam logic [5:0] FIN_AT_RST    = 6'h00;
  localparam logic [4:0] FIN_DT_RST    = 5'h00;

  // field positions inside the gain and battery control register
  localparam int TSE_POS  = 7;
  localparam int BATTERY_COMP_ENABLE_POS = 6;
  localparam int BATTERY_COMP_RATE_POS = 5;
  localparam int GAIN_POS = 0;

  // timing
  localparam int CLK_MHZ          = 200;
  localparam int CONV_TIME_MS     = 22;
  localparam int CONV_CYCLES      = CONV_TIME_MS * CLK_MHZ * 1000;
  localparam int SEC_CYCLES       = CLK_MHZ * 1000000;
  localparam int SEC_PER_MIN      = 60;
  localparam int PERIOD_SLOW_MIN  = 10;
  localparam int PERIOD_FAST_MIN  = 1;
  localparam int PERIOD_SLOW_SECS = PERIOD_SLOW_MIN * SEC_PER_MIN;
  localparam int PERIOD_FAST_SECS = PERIOD_FAST_MIN * SEC_PER_MIN;

  // trim encodings
  localparam logic [3:0] DT_MAG_MAX    = 4'hA;
  localparam logic [5:0] GAIN_UNITY_16 = 6'h10;
  localparam logic [5:0] AT_CODE_MAX   = 6'h3F;

  typedef struct packed {
    logic       temp_sense_enable;
    logic       battery_comp_enable;
    logic       battery_comp_rate;
    logic [4:0] gain;
  } rtc_ctl_t;

  typedef struct packed {
    logic [5:0] at;
    logic [4:0] dt;
  } rtc_trim_t;

endpackage

// [rtc_tcc_trim.sv]
// trim arithmetic: applies the gain-scaled analog correction and the sign-magnitude digital trim
// assumes corrections come from the compensation engine on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtc_tcc_trim
  import rtc_tcc_pkg::*;
(
  // settings
  input  wire logic [4:0]        gain,
  input  wire rtc_trim_t         init,
  // corrections in nominal steps
  input  wire logic signed [6:0] at_corr,
  input  wire logic signed [4:0] dt_corr,
  // result
  output var  rtc_trim_t         result
);

  // factor in sixteenths: top bit 0 shrinks from 16/16, top bit 1 grows from 17/16
  function automatic logic [5:0] gain_factor(input logic [4:0] g);
    gain_factor = g[4] ? 6'(GAIN_UNITY_16 + 6'h01 + {2'b00, g[3:0]})
                       : 6'(GAIN_UNITY_16 - {2'b00, g[3:0]});
  endfunction

  function automatic logic signed [5:0] dt_to_int(input logic [4:0] d);
    dt_to_int = d[4] ? -$signed({2'b00, d[3:0]}) : $signed({2'b00, d[3:0]});
  endfunction

  function automatic logic [4:0] int_to_dt(input logic signed [6:0] v);
    logic [6:0] mag;
    mag = v[6] ? 7'(-v) : 7'(v);
    if (mag > {3'b000, DT_MAG_MAX}) begin
      mag = {3'b000, DT_MAG_MAX};
    end
    int_to_dt = {v[6], mag[3:0]};
  endfunction

  wire logic signed [13:0] at_prod   = 14'(at_corr * $signed({1'b0, gain_factor(gain)}));
  wire logic signed [9:0]  at_offset = 10'(at_prod >>> 4);
  wire logic signed [10:0] at_sum    = 11'($signed({5'b00000, init.at}) - at_offset);
  wire logic signed [6:0]  dt_sum    = 7'(dt_to_int(init.dt) + dt_corr);

  assign result.at = at_sum < 0 ? 6'h00 : (at_sum > $signed({5'b00000, AT_CODE_MAX}) ? AT_CODE_MAX : at_sum[5:0]);
  assign result.dt = int_to_dt(dt_sum);

endmodule
`default_nettype wire

// [rtc_tcc_ctrl.sv]
// temperature compensation control: gain and battery-mode register, sensing scheduler, final trim readback
// assumes a byte register port from the serial front end and analog sensor results on the same clock
`timescale 1ns/1ps
`default_nettype none
module rtc_tcc_ctrl
  import rtc_tcc_pkg::*;
#(
  parameter int SEC_CYCLES_P  = SEC_CYCLES,
  parameter int CONV_CYCLES_P = CONV_CYCLES
)(
  // clock and reset
  input  wire logic              mclk,
  input  wire logic              rstn,
  // register port
  input  wire logic [7:0]        reg_addr,
  input  wire logic [7:0]        reg_wdata,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [7:0]             reg_rdata,
  // supply status pins
  input  wire logic              battery_mode,
  input  wire logic              vbat_low,
  // initial trims
  input  wire logic [5:0]        initial_analog_trim,
  input  wire logic [4:0]        initial_digital_trim,
  // sensor and compensation engine
  output logic                   conv_busy,
  output logic                   cycle_done,
  input  wire logic signed [6:0] at_corr,
  input  wire logic signed [4:0] dt_corr,
  // trims to the oscillator
  output logic [5:0]             final_analog_trim,
  output logic [4:0]             final_digital_trim
);

  typedef enum logic {ST_IDLE, ST_CONV} rtc_state_t;

  rtc_state_t state_ff;
  rtc_state_t nxt_state;
  rtc_ctl_t   ctl_ff;
  rtc_trim_t  fin_ff;
  rtc_trim_t  trim_res;
  logic [4:0] gain_snap_ff;
  logic [7:0] reg_rdata_ff;
  logic       bat_s1_ff;
  logic       bat_ff;
  logic       low_s1_ff;
  logic       low_ff;
  logic       start_req_ff;
  logic [31:0] sec_cnt_ff;
  logic [9:0]  per_cnt_ff;
  logic [31:0] conv_cnt_ff;

  // decode
  wire logic wr_ctl      = reg_wr && (reg_addr == ADDR_GAIN_CTL);
  wire logic tse_wr      = wr_ctl && reg_wdata[TSE_POS];
  wire logic comp_ok     = ctl_ff.temp_sense_enable && (!bat_ff || (ctl_ff.battery_comp_enable && !low_ff));
  wire logic sec_tick    = comp_ok && (sec_cnt_ff == 32'(SEC_CYCLES_P - 1));
  wire logic [9:0] per_secs = (bat_ff && !ctl_ff.battery_comp_rate) ? 10'(PERIOD_SLOW_SECS) : 10'(PERIOD_FAST_SECS);
  wire logic per_tick    = sec_tick && (per_cnt_ff == 10'(per_secs - 10'h001));
  wire logic start       = (state_ff == ST_IDLE) && comp_ok && (start_req_ff || per_tick);
  wire logic conv_end    = (state_ff == ST_CONV) && (conv_cnt_ff == 32'(CONV_CYCLES_P - 1));
  wire rtc_trim_t init_trim = '{at: initial_analog_trim, dt: initial_digital_trim};

  wire logic [7:0] rd_mux = (reg_addr == ADDR_GAIN_CTL) ? ctl_ff :
                            (reg_addr == ADDR_FIN_AT)   ? {2'b00, fin_ff.at} :
                            (reg_addr == ADDR_FIN_DT)   ? {3'b000, fin_ff.dt} : 8'h00;

  rtc_tcc_trim u_trim (
    .gain    (gain_snap_ff),
    .init    (init_trim),
    .at_corr (at_corr),
    .dt_corr (dt_corr),
    .result  (trim_res)
  );

  // pin synchronisers
  always_ff @(posedge mclk) begin
    bat_s1_ff <= battery_mode;
    bat_ff    <= bat_s1_ff;
    low_s1_ff <= vbat_low;
    low_ff    <= low_s1_ff;
  end

  // only the gain/control register is writable
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      ctl_ff       <= GAIN_CTL_RST;
      reg_rdata_ff <= 8'h00;
    end else begin
      if (wr_ctl) begin
        ctl_ff <= reg_wdata;
      end
      if (reg_rd) begin
        reg_rdata_ff <= rd_mux;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn || !ctl_ff.temp_sense_enable && !tse_wr) begin
      start_req_ff <= 1'b0;
    end else if (tse_wr) begin
      start_req_ff <= 1'b1;
    end else if (start) begin
      start_req_ff <= 1'b0;
    end
  end

  // period counters cleared while gated off
  always_ff @(posedge mclk) begin
    if (!rstn || !comp_ok) begin
      sec_cnt_ff <= 32'h00000000;
      per_cnt_ff <= 10'h000;
    end else begin
      sec_cnt_ff <= sec_tick ? 32'h00000000 : 32'(sec_cnt_ff + 32'h00000001);
      if (per_tick) begin
        per_cnt_ff <= 10'h000;
      end else if (sec_tick) begin
        per_cnt_ff <= 10'(per_cnt_ff + 10'h001);
      end
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (start) begin
          nxt_state = ST_CONV;
        end
      end
      ST_CONV: begin
        if (!comp_ok || conv_end) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_ff    <= ST_IDLE;
      conv_cnt_ff <= 32'h00000000;
    end else begin
      state_ff    <= nxt_state;
      conv_cnt_ff <= (state_ff == ST_CONV) ? 32'(conv_cnt_ff + 32'h00000001) : 32'h00000000;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gain_snap_ff <= GAIN_CTL_RST[4:0];
    end else if (start) begin
      gain_snap_ff <= ctl_ff.gain;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rstn) begin
      fin_ff <= '{at: FIN_AT_RST, dt: FIN_DT_RST};
    end else if (!ctl_ff.temp_sense_enable) begin
      fin_ff <= init_trim;
    end else if (conv_end && comp_ok) begin
      fin_ff <= trim_res;
    end
  end

  assign reg_rdata          = reg_rdata_ff;
  assign conv_busy          = (state_ff == ST_CONV);
  assign cycle_done         = conv_end && comp_ok;
  assign final_analog_trim  = fin_ff.at;
  assign final_digital_trim = fin_ff.dt;

  // helper: busy length counter
  logic [31:0] busy_len_ff;
  always_ff @(posedge mclk) begin
    if (!rstn || !conv_busy) begin
      busy_len_ff <= 32'h00000000;
    end else begin
      busy_len_ff <= 32'(busy_len_ff + 32'h00000001);
    end
  end

  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rstn);

  batt_enable_gate_a: assert property (conv_busy && bat_ff && !ctl_ff.battery_comp_enable |=> !conv_busy)
    else $error("battery conversion without enable");
  low_batt_gate_a: assert property (cycle_done |-> !(bat_ff && low_ff))
    else $error("correction with low battery");
  rate_interval_a: assert property (per_tick && bat_ff |-> per_cnt_ff == (ctl_ff.battery_comp_rate ? 10'd59 : 10'd599))
    else $error("wrong compensation interval");
  period_off_a: assert property (bat_ff && !ctl_ff.battery_comp_enable |-> !start ##1 per_cnt_ff == 10'h000)
    else $error("battery period runs while disabled");
  conv_length_a: assert property (cycle_done |-> busy_len_ff == 32'(CONV_CYCLES_P - 1))
    else $error("conversion length wrong");
  gain_capture_a: assert property ($rose(conv_busy) |-> gain_snap_ff == $past(ctl_ff.gain))
    else $error("gain not captured at cycle start");
  analog_readback_a: assert property (reg_rd && reg_addr == ADDR_FIN_AT |=> reg_rdata == {2'b00, $past(fin_ff.at)})
    else $error("analog readback mismatch");
  digital_readback_a: assert property (reg_rd && reg_addr == ADDR_FIN_DT |=> reg_rdata[7:5] == 3'b000)
    else $error("digital readback upper bits set");
  dt_magnitude_a: assert property (ctl_ff.temp_sense_enable |-> final_digital_trim[3:0] <= DT_MAG_MAX)
    else $error("digital trim magnitude above ten");
  tse_start_a: assert property (tse_wr && !conv_busy && (!bat_ff || (reg_wdata[BATTERY_COMP_ENABLE_POS] && !low_ff)) |=> ##1 conv_busy)
    else $error("enable write did not start a cycle");
  init_trim_a: assert property (!ctl_ff.temp_sense_enable |=> final_analog_trim == $past(initial_analog_trim))
    else $error("initial trim not used");
  final_hold_a: assert property (ctl_ff.temp_sense_enable && !cycle_done |=> $stable(fin_ff))
    else $error("final trim changed mid cycle");

endmodule
`default_nettype wire

// [tb.sv]
// self-checking bench for the temperature compensation control block
// assumes rtc_tcc_pkg and rtc_tcc_ctrl are compiled first; second and conversion counts are shortened
`timescale 1ns/1ps
`default_nettype none
module tb
  import rtc_tcc_pkg::*;
();
  logic              mclk         = 1'b0;
  logic              rstn         = 1'b0;
  logic [7:0]        reg_addr     = 8'h00;
  logic [7:0]        reg_wdata    = 8'h00;
  logic              reg_wr       = 1'b0;
  logic              reg_rd       = 1'b0;
  logic              battery_mode = 1'b0;
  logic              vbat_low     = 1'b0;
  logic [5:0]        iat          = 6'h20;
  logic [4:0]        idt          = 5'h03;
  logic signed [6:0] at_corr      = 7'sh00;
  logic signed [4:0] dt_corr      = 5'sh00;
  logic [7:0]        reg_rdata;
  logic              conv_busy;
  logic              cycle_done;
  logic [5:0]        fat;
  logic [4:0]        fdt;
  int                fails        = 0;
  int                checks_done  = 0;

  always #2.5 mclk = ~mclk;

  rtc_tcc_ctrl #(.SEC_CYCLES_P(20), .CONV_CYCLES_P(10)) i_rtc_tcc_ctrl (
    .mclk(mclk), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .battery_mode(battery_mode), .vbat_low(vbat_low),
    .initial_analog_trim(iat), .initial_digital_trim(idt), .conv_busy(conv_busy),
    .cycle_done(cycle_done), .at_corr(at_corr), .dt_corr(dt_corr),
    .final_analog_trim(fat), .final_digital_trim(fdt));

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
  endtask

  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  // counts edges until conv_busy reaches the wanted level, bounded
  task automatic wait_lvl(input logic v, output int n);
    n = 0;
    while (n < 20000 && conv_busy !== v) begin
      @(posedge mclk);
      #1 n++;
    end
    if (n >= 20000) fails++;
  endtask

  // two-step control write, one conversion, then final trims on ports and registers
  task automatic t_cycle(input logic [7:0] ctl, input logic signed [6:0] ac, input logic signed [4:0] dc,
                         input logic [5:0] eat, input logic [4:0] edt);
    int n;
    wr(ADDR_GAIN_CTL, ctl & 8'h7F);
    at_corr <= ac;
    dt_corr <= dc;
    wr(ADDR_GAIN_CTL, ctl);
    wait_lvl(1'b1, n);
    chk({2'b00, fat}, 8'h20);
    n = 0;
    while (n < 100 && cycle_done !== 1'b1) begin
      @(posedge mclk);
      #1 n++;
    end
    chk({7'h00, cycle_done}, 8'h01);
    @(posedge mclk);
    #1 chk({2'b00, fat}, {2'b00, eat});
    chk({3'b000, fdt}, {3'b000, edt});
    rchk(ADDR_FIN_AT, {2'b00, eat});
    rchk(ADDR_FIN_DT, {3'b000, edt});
    rchk(ADDR_GAIN_CTL, ctl);
  endtask

  // supply gating: does a sense request start a conversion
  task automatic t_gate(input logic bm, input logic vl, input logic [7:0] ctl, input logic exp);
    int n;
    logic seen;
    battery_mode <= bm;
    vbat_low     <= vl;
    wr(ADDR_GAIN_CTL, ctl & 8'h7F);
    repeat (4) @(posedge mclk);
    wr(ADDR_GAIN_CTL, ctl);
    seen = 1'b0;
    for (n = 0; n < 40; n++) begin
      @(posedge mclk);
      #1 seen = seen | (conv_busy === 1'b1);
    end
    chk({7'h00, seen}, {7'h00, exp});
  endtask

  // battery-mode period between two conversion starts, and conversion length
  task automatic t_rate(input logic [7:0] ctl, input int gap);
    int n0, n1, n2;
    battery_mode <= 1'b1;
    vbat_low     <= 1'b0;
    wr(ADDR_GAIN_CTL, ctl & 8'h7F);
    repeat (4) @(posedge mclk);
    wr(ADDR_GAIN_CTL, ctl);
    wait_lvl(1'b1, n0);
    wait_lvl(1'b0, n1);
    wait_lvl(1'b1, n2);
    chk({7'h00, n1 >= 9 && n1 <= 11}, 8'h01);
    chk({7'h00, n1 + n2 >= gap - 20 && n1 + n2 <= gap + 20}, 8'h01);
  endtask

  initial begin
    #(60000 * 5);
    fails++;
    tally_and_finish();
  end

  initial begin
    repeat (10) @(posedge mclk);
    rstn <= 1'b1;
    rchk(ADDR_GAIN_CTL, GAIN_CTL_RST);
    rchk(ADDR_FIN_AT, 8'h20);
    rchk(ADDR_FIN_DT, 8'h03);
    rchk(8'h20, 8'h00);
    wr(ADDR_FIN_AT, 8'hFF);
    wr(ADDR_FIN_DT, 8'hFF);
    rchk(ADDR_FIN_AT, 8'h20);
    rchk(ADDR_FIN_DT, 8'h03);
    t_cycle(8'h80, 7'sd16, -5'sd5, 6'h10, 5'h12);
    t_cycle(8'h9F, 7'sd16, 5'sd15, 6'h00, 5'h0A);
    t_cycle(8'h88, 7'sd16, -5'sd15, 6'h18, 5'h1A);
    t_cycle(8'h90, 7'sd16, 5'sd0, 6'h0F, 5'h03);
    wr(ADDR_GAIN_CTL, 8'h00);
    iat <= 6'h05;
    repeat (3) @(posedge mclk);
    #1 chk({2'b00, fat}, 8'h05);
    @(posedge mclk);
    iat <= 6'h20;
    t_gate(1'b0, 1'b0, 8'h80, 1'b1);
    t_gate(1'b1, 1'b0, 8'hA0, 1'b0);
    t_gate(1'b1, 1'b1, 8'hC0, 1'b0);
    t_gate(1'b1, 1'b0, 8'hC0, 1'b1);
    t_rate(8'hE0, 1200);
    t_rate(8'hC0, 12000);
    tally_and_finish();
  end
endmodule
`default_nettype wire
